// ===== hdl/ppgd_pkg.sv
// Constants and types shared by the pattern generator and detector
package ppgd_pkg;

	// ********************************************************************
	// Register indices (byte address is four times the index)
	// ********************************************************************
	localparam logic [7:0] IDX_CONTROL = 8'he0;
	localparam logic [7:0] IDX_STATUS  = 8'he1;
	localparam logic [7:0] IDX_LENGTH  = 8'he2;
	localparam logic [7:0] IDX_TAP     = 8'he3;
	localparam logic [7:0] IDX_SEED    = 8'he8;
	localparam logic [7:0] IDX_READ0   = 8'hec;
	localparam logic [7:0] IDX_READ3   = 8'hef;

	// ********************************************************************
	// Control and status register fields and reset values
	// ********************************************************************
	localparam int CTRL_SEL_HI = 7;
	localparam int CTRL_SEL_LO = 6;
	localparam int CTRL_ZS     = 5;
	localparam int CTRL_PTYPE  = 4;
	localparam int CTRL_TX_PATTERN_INVERT   = 3;
	localparam int CTRL_RX_STREAM_INVERT   = 2;
	localparam int CTRL_AUTO   = 1;
	localparam int CTRL_MAN    = 0;
	localparam int STATUS_LOCK = 4;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [4:0] LEN_RESET  = 5'h00;
	localparam logic [4:0] TAP_RESET  = 5'h00;
	localparam logic [7:0] SEED_RESET = 8'h01;

	localparam logic [1:0] SEL_ERR = 2'h2;
	localparam logic [1:0] SEL_BIT = 2'h3;

	// ********************************************************************
	// Detector and suppression counts, in bit periods
	// ********************************************************************
	localparam logic [5:0] LOCK_RUN  = 6'h30;
	localparam logic [5:0] WIN_BITS  = 6'h30;
	localparam logic [3:0] ERR_LIMIT = 4'ha;
	localparam logic [3:0] ZERO_RUN  = 4'he;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {
		DET_HUNT = 2'b00,
		DET_LOCK = 2'b01,
		DET_LOST = 2'b11
	} ppgd_det_e;

endpackage

// ===== hdl/ppgd_buf2.sv
// Two-entry buffer between the pattern generator and the transmit stream
`timescale 1ns/10ps
`default_nettype none
module ppgd_buf2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);

	typedef struct packed {
		logic             head_valid;
		logic [WIDTH-1:0] head_data;
		logic             tail_valid;
		logic [WIDTH-1:0] tail_data;
	} ppgd_buf_s;

	ppgd_buf_s s;
	ppgd_buf_s next_s;
	logic      pop;
	logic      push;

	assign in_ready  = !s.tail_valid;
	assign out_valid = s.head_valid;
	assign out_data  = s.head_data;

	always_comb begin
		next_s = s;
		pop    = s.head_valid && out_ready;
		push   = in_valid && !s.tail_valid;
		if (pop) begin
			// Tail moves up first so order is kept
			if (s.tail_valid) begin
				next_s.head_data  = s.tail_data;
				next_s.tail_valid = 1'b0;
			end else begin
				next_s.head_valid = push;
				next_s.head_data  = in_data;
			end
		end else if (push) begin
			if (!s.head_valid) begin
				next_s.head_valid = 1'b1;
				next_s.head_data  = in_data;
			end else begin
				next_s.tail_valid = 1'b1;
				next_s.tail_data  = in_data;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule
`default_nettype wire

// ===== hdl/ppgd_top.sv
// Pattern generator and detector with its AHB-Lite register slave
//
// Function
// - Readout select picks pattern, errors or bits
// - Zero suppression forces one after fourteen zeros
// - Detector expects the same suppression ones
// - Type bit chooses repetitive or pseudo-random
// - Transmit invert flips every generated bit
// - Receive invert flips bits before detection
// - Auto resync after ten errors in window
// - Without auto, only manual trigger resyncs
// - Manual resync on rising trigger bit only
// - Lock after 48 clean bits, loss rule
// - Pattern length is length field plus one
// - Feedback tap is tap field plus one
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ppgd_top
	import ppgd_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        tx_bit_en,
	output logic             tx_bit,
	output logic             tx_bit_valid,
	input  wire logic        tx_bit_ready,
	input  wire logic        rx_bit_en,
	input  wire logic        rx_bit,
	output logic             lock_state
);

	// ********************************************************************
	// State
	// ********************************************************************
	typedef struct packed {
		logic        ph_act;
		logic        ph_wr;
		logic        ph_ok;
		logic [7:0]  ph_idx;
		logic        hreadyout;
		logic [31:0] hrdata;
		logic [7:0]  ctrl;
		logic [4:0]  len;
		logic [4:0]  tap;
		logic [7:0]  seed;
		logic [31:0] gsr;
		logic [3:0]  gzrun;
		logic [31:0] dsr;
		logic [3:0]  dzrun;
		ppgd_det_e   dstate;
		logic        lock;
		logic [5:0]  run;
		logic [5:0]  win_cnt;
		logic [3:0]  win_err;
		logic [31:0] bit_cnt;
		logic [31:0] err_cnt;
		logic [31:0] rx_pat;
		logic [31:0] hold_pat;
		logic [31:0] hold_err;
		logic [31:0] hold_bit;
	} ppgd_top_s;

	ppgd_top_s   s;
	ppgd_top_s   next_s;
	logic        accept;
	logic        wr_now;
	logic [7:0]  wdata;
	logic        resync_req;
	logic        gen_reload;
	logic        xfer;
	logic        buf_in_ready;
	logic        gen_push;
	logic        gen_raw;
	logic        gen_forced;
	logic        gen_bit;
	logic        rbit;
	logic        d_forced;
	logic        d_exp_raw;
	logic        d_err;
	logic [3:0]  err_sum;
	logic [1:0]  rsel;
	logic [31:0] rword;

	// Next pattern bit from the oldest bit, XORed with the tap bit unless repetitive
	function automatic logic next_bit(input logic [31:0] sr,
			input logic [4:0] len, input logic [4:0] tap,
			input logic repeat_mode);
		next_bit = sr[len];
		if (!repeat_mode) begin
			next_bit = sr[len] ^ sr[tap];
		end
	endfunction

	// Zero run counter, saturating at the suppression limit
	function automatic logic [3:0] zrun_next(input logic [3:0] zr,
			input logic b);
		if (b) begin
			zrun_next = 4'h0;
		end else if (zr == ZERO_RUN) begin
			zrun_next = zr;
		end else begin
			zrun_next = zr + 4'h1;
		end
	endfunction

	assign hreadyout  = s.hreadyout;
	assign hresp      = 1'b0;
	assign hrdata     = s.hrdata;
	assign lock_state = s.lock;

	// ********************************************************************
	// Transmit buffer
	// ********************************************************************
	ppgd_buf2 #(
		.WIDTH (1)
	) u_buf (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.in_valid  (gen_push),
		.in_data   (gen_bit),
		.in_ready  (buf_in_ready),
		.out_valid (tx_bit_valid),
		.out_data  (tx_bit),
		.out_ready (tx_bit_ready)
	);

	// ********************************************************************
	// Next state
	// ********************************************************************
	always_comb begin
		next_s     = s;
		accept     = hsel && hready && (htrans == HTRANS_NONSEQ);
		wr_now     = s.ph_act && s.ph_wr && s.ph_ok;
		wdata      = hwdata[7:0];
		resync_req = 1'b0;
		gen_reload = 1'b0;
		xfer       = 1'b0;
		rsel       = s.ctrl[CTRL_SEL_HI:CTRL_SEL_LO];
		rword      = 32'h0000_0000;
		err_sum    = s.win_err;

		// Bus data phase: one wait state so read data leaves a flop
		if (s.ph_act) begin
			next_s.ph_act    = 1'b0;
			next_s.hreadyout = 1'b1;
			next_s.hrdata    = 32'h0000_0000;
		end
		if (wr_now) begin
			if (s.ph_idx == IDX_CONTROL) begin
				next_s.ctrl = wdata;
				resync_req  = wdata[CTRL_MAN] && !s.ctrl[CTRL_MAN];
				gen_reload  = 1'b1;
			end else if (s.ph_idx == IDX_LENGTH) begin
				next_s.len = wdata[4:0];
				gen_reload = 1'b1;
			end else if (s.ph_idx == IDX_TAP) begin
				next_s.tap = wdata[4:0];
				gen_reload = 1'b1;
			end else if (s.ph_idx == IDX_SEED) begin
				next_s.seed = wdata;
				gen_reload  = 1'b1;
			end else if (s.ph_idx >= IDX_READ0 && s.ph_idx <= IDX_READ3) begin
				xfer = 1'b1;
			end
		end else if (s.ph_act && s.ph_ok) begin
			if (rsel == SEL_ERR) begin
				rword = s.hold_err;
			end else if (rsel == SEL_BIT) begin
				rword = s.hold_bit;
			end else begin
				rword = s.hold_pat;
			end
			if (s.ph_idx == IDX_CONTROL) begin
				next_s.hrdata = {24'h00_0000, s.ctrl};
			end else if (s.ph_idx == IDX_STATUS) begin
				next_s.hrdata = {24'h00_0000, 3'h0, s.lock, 4'h0};
			end else if (s.ph_idx == IDX_LENGTH) begin
				next_s.hrdata = {24'h00_0000, 3'h0, s.len};
			end else if (s.ph_idx == IDX_TAP) begin
				next_s.hrdata = {24'h00_0000, 3'h0, s.tap};
			end else if (s.ph_idx == IDX_SEED) begin
				next_s.hrdata = {24'h00_0000, s.seed};
			end else if (s.ph_idx == IDX_READ0) begin
				next_s.hrdata = {24'h00_0000, rword[7:0]};
			end else if (s.ph_idx == IDX_READ0 + 8'h01) begin
				next_s.hrdata = {24'h00_0000, rword[15:8]};
			end else if (s.ph_idx == IDX_READ0 + 8'h02) begin
				next_s.hrdata = {24'h00_0000, rword[23:16]};
			end else if (s.ph_idx == IDX_READ3) begin
				next_s.hrdata = {24'h00_0000, rword[31:24]};
			end
		end
		if (accept) begin
			next_s.ph_act    = 1'b1;
			next_s.ph_wr     = hwrite;
			next_s.ph_ok     = (haddr[31:10] == 22'h00_0000) &&
				(haddr[1:0] == 2'h0);
			next_s.ph_idx    = haddr[9:2];
			next_s.hreadyout = 1'b0;
		end

		// Generator: stalls rather than drops when the buffer is full
		gen_push   = tx_bit_en && buf_in_ready;
		gen_raw    = next_bit(s.gsr, s.len, s.tap, s.ctrl[CTRL_PTYPE]);
		gen_forced = s.ctrl[CTRL_ZS] && (s.gzrun == ZERO_RUN);
		gen_bit    = (gen_raw | gen_forced) ^ s.ctrl[CTRL_TX_PATTERN_INVERT];
		if (gen_push) begin
			next_s.gsr   = {s.gsr[30:0], gen_raw};
			next_s.gzrun = zrun_next(s.gzrun, gen_raw | gen_forced);
		end
		// Any setup write restarts the pattern; a type or seed in the same write is used
		if (gen_reload) begin
			next_s.gzrun = 4'h0;
			if (next_s.ctrl[CTRL_PTYPE]) begin
				next_s.gsr = {24'h00_0000, next_s.seed};
			end else begin
				next_s.gsr = 32'hffff_ffff;
			end
		end

		// Detector
		rbit      = rx_bit ^ s.ctrl[CTRL_RX_STREAM_INVERT];
		d_exp_raw = next_bit(s.dsr, s.len, s.tap, s.ctrl[CTRL_PTYPE]);
		d_forced  = s.ctrl[CTRL_ZS] && (s.dzrun == ZERO_RUN);
		d_err     = rbit != (d_exp_raw | d_forced);
		if (rx_bit_en) begin
			next_s.bit_cnt = s.bit_cnt + 32'h0000_0001;
			next_s.rx_pat  = {s.rx_pat[30:0], rbit};
			next_s.dzrun   = zrun_next(s.dzrun, rbit);
			// Hunting follows the line; locked runs on its own
			if (s.dstate == DET_HUNT && !d_forced) begin
				next_s.dsr = {s.dsr[30:0], rbit};
			end else begin
				next_s.dsr = {s.dsr[30:0], d_exp_raw};
			end
			case (s.dstate)
				DET_HUNT: begin
					next_s.run = d_err ? 6'h00 : s.run + 6'h01;
					if (!d_err && s.run == LOCK_RUN - 6'h01) begin
						next_s.dstate  = DET_LOCK;
						next_s.win_cnt = 6'h00;
						next_s.win_err = 4'h0;
					end
				end
				DET_LOCK: begin
					err_sum = s.win_err + {3'h0, d_err};
					if (d_err) begin
						next_s.err_cnt = s.err_cnt + 32'h0000_0001;
					end
					next_s.win_cnt = s.win_cnt + 6'h01;
					next_s.win_err = err_sum;
					if (err_sum >= ERR_LIMIT) begin
						next_s.dstate  = s.ctrl[CTRL_AUTO] ? DET_HUNT : DET_LOST;
						next_s.run     = 6'h00;
						next_s.win_cnt = 6'h00;
						next_s.win_err = 4'h0;
					end else if (s.win_cnt == WIN_BITS - 6'h01) begin
						next_s.win_cnt = 6'h00;
						next_s.win_err = 4'h0;
					end
				end
				default: begin
				end
			endcase
		end
		if (s.dstate == DET_LOST && s.ctrl[CTRL_AUTO]) begin
			next_s.dstate = DET_HUNT;
			next_s.run    = 6'h00;
		end
		// Manual resync is the only way out when auto is off
		if (resync_req) begin
			next_s.dstate  = DET_HUNT;
			next_s.run     = 6'h00;
			next_s.win_cnt = 6'h00;
			next_s.win_err = 4'h0;
		end
		next_s.lock = (next_s.dstate == DET_LOCK);

		// Snapshot includes the bit seen this cycle, so none is lost
		if (xfer) begin
			next_s.hold_pat = next_s.rx_pat;
			next_s.hold_err = next_s.err_cnt;
			next_s.hold_bit = next_s.bit_cnt;
			next_s.err_cnt  = 32'h0000_0000;
			next_s.bit_cnt  = 32'h0000_0000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s           <= '0;
			s.hreadyout <= 1'b1;
			s.ctrl      <= CTRL_RESET;
			s.len       <= LEN_RESET;
			s.tap       <= TAP_RESET;
			s.seed      <= SEED_RESET;
			s.gsr       <= 32'hffff_ffff;
			s.dstate    <= DET_HUNT;
		end else begin
			s <= next_s;
		end
	end

	// ********************************************************************
	// Assertions
	// ********************************************************************
	a_lock_gain: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.dstate == DET_HUNT && rx_bit_en && !d_err && s.run == 6'h2f &&
		!resync_req) |=> lock_state)
		else $error("lock not gained after 48 clean bits");

	a_lock_loss: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.dstate == DET_LOCK && rx_bit_en && d_err && s.win_err == 4'h9)
		|=> !lock_state)
		else $error("lock kept after tenth error in window");

	a_auto_hunt: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.dstate == DET_LOCK && rx_bit_en && d_err && s.win_err == 4'h9 &&
		s.ctrl[CTRL_AUTO]) |=> s.dstate == DET_HUNT)
		else $error("auto resync did not start");

	a_no_auto: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.dstate == DET_LOST && !s.ctrl[CTRL_AUTO] && !resync_req)
		|=> s.dstate == DET_LOST)
		else $error("detector left lost state on its own");

	a_manual_edge: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_now && s.ph_idx == IDX_CONTROL && wdata[CTRL_MAN] &&
		!s.ctrl[CTRL_MAN]) |=> (s.dstate == DET_HUNT && !lock_state))
		else $error("manual resync edge ignored");

	a_zero_force: assert property (@(posedge hclk) disable iff (!hresetn)
		(gen_push && s.ctrl[CTRL_ZS] && s.gzrun == ZERO_RUN)
		|=> s.gzrun == 4'h0)
		else $error("zero run not broken by forced one");

	a_rx_invert: assert property (@(posedge hclk) disable iff (!hresetn)
		(rx_bit_en && s.dstate == DET_HUNT && !d_forced)
		|=> s.dsr[0] == $past(rx_bit ^ s.ctrl[CTRL_RX_STREAM_INVERT]))
		else $error("received bit not inverted as set");

	a_read_select: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.ph_act && !s.ph_wr && s.ph_ok && s.ph_idx == IDX_READ0 &&
		s.ctrl[CTRL_SEL_HI:CTRL_SEL_LO] == SEL_BIT)
		|=> hrdata[7:0] == $past(s.hold_bit[7:0]) && hreadyout)
		else $error("readout select gave wrong byte");

	a_bus_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		accept |=> !hreadyout ##1 hreadyout)
		else $error("data phase not one wait state long");

endmodule
`default_nettype wire

// ===== verification/ppgd_line_model.sv
// Far-end line model: takes transmit bits and loops them back on receive
`timescale 1ns/10ps
`default_nettype none
module ppgd_line_model (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic tx_bit,
	input  wire logic tx_bit_valid,
	output logic      tx_bit_ready,
	output logic      rx_bit_en,
	output logic      rx_bit,
	input  wire logic hold,
	input  wire logic corrupt
);
	// ****************************************************************
	// Loopback
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_bit_ready <= 1'b0;
			rx_bit_en    <= 1'b0;
			rx_bit       <= 1'b0;
		end else begin
			tx_bit_ready <= !hold;
			rx_bit_en    <= tx_bit_valid && tx_bit_ready;
			// Idle line toggles so a stale bit never looks like data
			if (tx_bit_valid && tx_bit_ready) begin
				rx_bit <= tx_bit ^ corrupt;
			end else begin
				rx_bit <= ~rx_bit;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verification/test_prbs_pattern_gen_detect.sv
// Self-checking bench of the pattern generator and detector
`timescale 1ns/10ps
`default_nettype none
module test_prbs_pattern_gen_detect
	import ppgd_pkg::*;
;
	typedef struct packed {
		logic       w;
		logic [7:0] idx;
		logic [7:0] d;
		logic [7:0] x;
	} ppgd_row_s;

	localparam ppgd_row_s ROWS [9] = '{
		'{1'b0, IDX_CONTROL, 8'h00, CTRL_RESET},
		'{1'b0, IDX_LENGTH, 8'h00, {3'h0, LEN_RESET}},
		'{1'b0, IDX_TAP, 8'h00, {3'h0, TAP_RESET}},
		'{1'b0, IDX_SEED, 8'h00, SEED_RESET},
		'{1'b0, IDX_STATUS, 8'h00, 8'h00},
		'{1'b1, IDX_LENGTH, 8'hff, 8'h1f},
		'{1'b1, IDX_TAP, 8'he7, 8'h07},
		'{1'b1, IDX_CONTROL, 8'hfe, 8'hfe},
		'{1'b1, 8'h10, 8'h55, 8'h00}
	};
	localparam logic [1:0] SELS [3] = '{2'h0, SEL_ERR, SEL_BIT};

	logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout;
	logic [31:0] haddr, hwdata, hrdata, rd, e;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        tx_bit_en, tx_bit, tx_bit_valid, tx_bit_ready;
	logic        rx_bit_en, rx_bit, lock_state, hold, corrupt;
	logic        cap[$];
	logic        ref_q[$];
	int          mismatches, n_checks, cyc;

	ppgd_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .tx_bit_en(tx_bit_en),
		.tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
		.tx_bit_ready(tx_bit_ready), .rx_bit_en(rx_bit_en),
		.rx_bit(rx_bit), .lock_state(lock_state));

	ppgd_line_model line_u (.hclk(hclk), .hresetn(hresetn), .tx_bit(tx_bit),
		.tx_bit_valid(tx_bit_valid), .tx_bit_ready(tx_bit_ready),
		.rx_bit_en(rx_bit_en), .rx_bit(rx_bit), .hold(hold),
		.corrupt(corrupt));

	// ****************************************************************
	// Clock, capture and watchdog
	// ****************************************************************
	always #25 hclk = ~hclk;

	always @(posedge hclk) begin
		if (tx_bit_valid === 1'b1 && tx_bit_ready === 1'b1) begin
			cap.push_back(tx_bit);
		end
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			finish_test();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask

	task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr  <= {22'h0, idx, 2'b00};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// Spaced enables so every bit has left the buffer before the next
	task bits(input int n, input logic c);
		corrupt <= c;
		repeat (n) begin
			tx_bit_en <= 1'b1;
			@(posedge hclk);
			tx_bit_en <= 1'b0;
			repeat (3) @(posedge hclk);
		end
	endtask

	task lock_is(input logic x);
		chk("lock_state", {31'h0, lock_state}, {31'h0, x});
	endtask

	task finish_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
		hsize = 3'h2; hwdata = 0; tx_bit_en = 0; hold = 0; corrupt = 0;
		repeat (16) @(posedge hclk);
		chk("reset outs", {hreadyout, hresp, tx_bit_valid, lock_state}, 4'h8);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (ROWS[i]) begin
			if (ROWS[i].w) bus(1'b1, ROWS[i].idx, ROWS[i].d);
			bus(1'b0, ROWS[i].idx, 8'h00);
			chk("register", rd, {24'h0, ROWS[i].x});
		end
		$display("test registers done");
		// Type bit first, then the rest of the setup
		bus(1'b1, IDX_CONTROL, 8'h00);
		bus(1'b1, IDX_LENGTH, 8'h06);
		bus(1'b1, IDX_TAP, 8'h05);
		bits(47, 1'b0);
		lock_is(1'b0);
		bits(9, 1'b0);
		lock_is(1'b1);
		bits(9, 1'b1);
		bits(40, 1'b0);
		lock_is(1'b1);
		bits(48, 1'b1);
		lock_is(1'b0);
		bits(100, 1'b0);
		lock_is(1'b0);
		bus(1'b1, IDX_CONTROL, 8'h01);
		bits(64, 1'b0);
		lock_is(1'b1);
		bits(48, 1'b1);
		bus(1'b1, IDX_CONTROL, 8'h01);
		bits(100, 1'b0);
		lock_is(1'b0);
		bus(1'b1, IDX_CONTROL, 8'h00);
		bus(1'b1, IDX_CONTROL, 8'h01);
		bits(64, 1'b0);
		lock_is(1'b1);
		$display("test manual resync done");
		bus(1'b1, IDX_CONTROL, 8'h02);
		bits(120, 1'b0);
		lock_is(1'b1);
		bits(48, 1'b1);
		lock_is(1'b0);
		bits(64, 1'b0);
		lock_is(1'b1);
		bus(1'b1, IDX_CONTROL, 8'h0e);
		bits(120, 1'b0);
		lock_is(1'b1);
		bus(1'b1, IDX_CONTROL, 8'h0a);
		bits(120, 1'b0);
		lock_is(1'b0);
		$display("test auto resync done");
		foreach (SELS[j]) begin
			bus(1'b1, IDX_CONTROL, {SELS[j], 6'h02});
			bits(120, 1'b0);
			bus(1'b1, IDX_READ0, 8'h00);
			bits(5, 1'b1);
			cap.delete();
			bits(35, 1'b0);
			bus(1'b1, IDX_READ0, 8'h00);
			for (int k = 0; k < 32; k++) e[k] = cap[cap.size() - 1 - k];
			if (SELS[j] == SEL_ERR) e = 32'h0000_0005;
			if (SELS[j] == SEL_BIT) e = 32'h0000_0028;
			for (int k = 0; k < 4; k++) begin
				bus(1'b0, IDX_READ0 + 8'(k), 8'h00);
				chk("readout", rd, {24'h0, e[8*k +: 8]});
			end
		end
		$display("test readout done");
		// ************************************************************
		// Generator output
		// ************************************************************
		bus(1'b1, IDX_CONTROL, 8'h10);
		bus(1'b1, IDX_LENGTH, 8'h05);
		bus(1'b1, IDX_SEED, 8'h2d);
		cap.delete();
		bits(18, 1'b0);
		ref_q = cap;
		for (int k = 0; k < 12; k++) chk("period", cap[k], cap[k+6]);
		bus(1'b1, IDX_CONTROL, 8'h18);
		cap.delete();
		bits(18, 1'b0);
		for (int k = 0; k < 18; k++) begin
			chk("tx_pattern_invert", cap[k], {31'h0, ~ref_q[k]});
		end
		bus(1'b1, IDX_CONTROL, 8'h10);
		cap.delete();
		hold <= 1'b1;
		@(posedge hclk);
		tx_bit_en <= 1'b1;
		repeat (6) @(posedge hclk);
		tx_bit_en <= 1'b0;
		@(posedge hclk);
		chk("stalled", {30'h0, cap.size() == 0, tx_bit_valid},
			32'h0000_0003);
		hold <= 1'b0;
		// First enable meets a full buffer and is refused
		bits(17, 1'b0);
		chk("count", cap.size(), 32'h0000_0012);
		for (int k = 0; k < 18; k++) chk("order", cap[k], ref_q[k]);
		$display("test buffer done");
		bus(1'b1, IDX_LENGTH, 8'h0f);
		bus(1'b1, IDX_SEED, 8'h00);
		cap.delete();
		bits(20, 1'b0);
		for (int k = 0; k < 20; k++) chk("no zs", cap[k], 1'b0);
		bus(1'b1, IDX_CONTROL, 8'h30);
		cap.delete();
		bits(30, 1'b0);
		chk("zs run", {cap[13], cap[14], cap[28], cap[29]}, 4'h5);
		// Detector must expect the forced ones, else it never locks
		bus(1'b1, IDX_CONTROL, 8'h31);
		bits(100, 1'b0);
		lock_is(1'b1);
		$display("test zero suppression done");
		// Reset in mid-run drops lock and restores the control register
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		lock_is(1'b0);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, IDX_CONTROL, 8'h00);
		chk("ctrl reset", rd, {24'h0, CTRL_RESET});
		$display("test reset done");
		finish_test();
	end
endmodule
`default_nettype wire
